// ---- supmon_pkg.sv ----
// Package for the supply monitor control block: register map, field positions,
// reset value, state encoding and timing counts.
// Assumes a 25 MHz core clock; all counts are derived from that rate.
package supmon_pkg;

    // Register map
    localparam logic [7:0] CTRL_ADDR        = 8'hDF;
    localparam logic [7:0] CTRL_RESET       = 8'hDE;
    // Bits 7, 2 and 1 hold no state and read back as their reset pattern
    localparam logic [7:0] CTRL_FIXED_MASK  = 8'h86;

    // Field positions
    localparam int unsigned BIT_ENABLE      = 0;
    localparam int unsigned BIT_TRIP_LO     = 3;
    localparam int unsigned BIT_TRIP_HI     = 4;
    localparam int unsigned BIT_LOW_FLAG    = 5;
    localparam int unsigned BIT_DIG_CMP     = 6;

    // Trip point codes: 00 4.37 V, 01 3.08 V, 10 2.93 V, 11 2.63 V
    localparam logic [1:0] TRIP_4V37        = 2'h0;
    localparam logic [1:0] TRIP_3V08        = 2'h1;
    localparam logic [1:0] TRIP_2V93        = 2'h2;
    localparam logic [1:0] TRIP_2V63        = 2'h3;

    // Timing
    localparam longint CLK_HZ               = 25000000;
    localparam longint CLK_PERIOD_NS        = 40;
    localparam longint QUAL_TIME_MS         = 250;
    localparam longint QUAL_CYCLES          = QUAL_TIME_MS * (CLK_HZ / 1000);
    localparam longint GLITCH_TIME_NS       = 2000;
    localparam longint GLITCH_CYCLES        = (GLITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned QUAL_CNT_W      = 23;
    localparam int unsigned GLITCH_CNT_W    = 6;

    // Flag sequencer, Gray along idle -> low -> qualify
    typedef enum logic [1:0] {
        SUPMON_IDLE = 2'b00,
        SUPMON_LOW  = 2'b01,
        SUPMON_QUAL = 2'b11
    } supmon_state_type;

endpackage : supmon_pkg

// ---- supmon_filter.sv ----
// Synchroniser and glitch filter for one comparator output.
// Assumes the comparator is asynchronous to the core clock and idles high.
`timescale 1ns/1ns
module supmon_filter (
    input  wire logic CORE_CLK_I,   // Core clock
    input  wire logic SYS_RST_I,    // Synchronous reset, active high
    input  wire logic cmp_i,        // Raw comparator output
    output logic      level_o,      // Synchronised level
    output logic      filt_o        // Level after glitch rejection
);

    logic                                  s1_reg, s2_reg, s3_reg;
    logic                                  level_reg, level_next;
    logic                                  filt_reg, filt_next;
    logic [supmon_pkg::GLITCH_CNT_W-1:0]   cnt_reg, cnt_next;

    localparam logic [supmon_pkg::GLITCH_CNT_W-1:0] GLITCH_LAST =
        supmon_pkg::GLITCH_CNT_W'(supmon_pkg::GLITCH_CYCLES - 1);

    always_comb begin
        level_next = level_reg;
        filt_next  = filt_reg;
        cnt_next   = '0;
        // A change counts only once the second and third stages agree
        if (s2_reg == s3_reg) begin
            level_next = s3_reg;
        end
        // Filtered output follows only after the level holds for the full window
        if (level_reg != filt_reg) begin
            if (cnt_reg == GLITCH_LAST) begin
                filt_next = level_reg;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            s1_reg    <= 1'b1;
            s2_reg    <= 1'b1;
            s3_reg    <= 1'b1;
            level_reg <= 1'b1;
            filt_reg  <= 1'b1;
            cnt_reg   <= '0;
        end else begin
            s1_reg    <= cmp_i;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            level_reg <= level_next;
            filt_reg  <= filt_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign level_o = level_reg;
    assign filt_o  = filt_reg;

endmodule : supmon_filter

// ---- supmon_top.sv ----
// Control and status logic of the on-chip supply monitor: control register,
// trip point select, low-supply flag with 250 ms qualification, interrupt request.
// Assumes a single-cycle special-function-register access from the core and an
// interrupt enable bit supplied from the core's secondary enable register.
//
// Function
// - Control bit 0 written 1 enables the monitor, written 0 disables it.
// - Bit 6 reads the live digital comparator: 1 above trip, 0 below.
// - Low-supply flag bit 5 sets whenever either filtered comparator output is low while the monitor is enabled.
// - Both comparators high again starts 250 ms count; expiry clears the flag.
// - Software may write the flag, but cannot clear it while a supply is low.
// - Flag raises the core interrupt only when its secondary enable bit is set.
// - Bits 4:3 select trip: 00 4.37, 01 3.08, 10 2.93, 11 2.63 volts.
// - Short glitches on comparator outputs must not set the low-supply flag.
`timescale 1ns/1ns
module supmon_top #(
    parameter logic [supmon_pkg::QUAL_CNT_W-1:0] QUAL_CYCLES =
        supmon_pkg::QUAL_CNT_W'(supmon_pkg::QUAL_CYCLES)   // Qualification length
) (
    input  wire logic       CORE_CLK_I,          // Core clock, 25 MHz
    input  wire logic       SYS_RST_I,           // Synchronous reset, active high
    input  wire logic [7:0] SFR_ADDR_I,          // Register address
    input  wire logic [7:0] SFR_WDATA_I,         // Write data
    input  wire logic       SFR_WR_I,            // Write strobe, one cycle
    input  wire logic       SFR_RD_I,            // Read strobe, one cycle
    input  wire logic       IRQ_ENABLE_I,        // Monitor enable bit of the secondary irq register
    input  wire logic       DIG_CMP_I,           // Digital supply comparator, high when good
    input  wire logic       ANA_CMP_I,           // Analog supply comparator, high when good
    output logic [7:0]      SFR_RDATA_O,         // Read data, valid the cycle after the strobe
    output logic            MONITOR_ENABLE_O,    // Enable to the analog comparators
    output logic [1:0]      TRIP_SELECT_O,       // Digital trip point code
    output logic            LOW_SUPPLY_IRQ_O     // Interrupt request to the core
);

    logic                                dig_level;
    logic                                dig_filt;
    logic                                ana_filt;

    logic                                enable_reg, enable_next;
    logic [1:0]                          trip_reg, trip_next;
    logic                                flag_reg, flag_next;
    logic [7:0]                          rdata_reg, rdata_next;
    logic                                irq_reg, irq_next;
    logic                                supply_low;
    logic                                reg_hit_wr;
    logic                                reg_hit_rd;
    supmon_pkg::supmon_state_type        state_reg, state_next;
    logic [supmon_pkg::QUAL_CNT_W-1:0]   qual_reg, qual_next;

    localparam logic [supmon_pkg::QUAL_CNT_W-1:0] QUAL_LAST = QUAL_CYCLES - 1'b1;

    // Register address decode, shared by the read and write paths
    function automatic logic ctrl_hit(input logic [7:0] addr);
        ctrl_hit = (addr == supmon_pkg::CTRL_ADDR);
    endfunction : ctrl_hit

    supmon_filter u_dig_filter (
        .CORE_CLK_I (CORE_CLK_I),
        .SYS_RST_I  (SYS_RST_I),
        .cmp_i      (DIG_CMP_I),
        .level_o    (dig_level),
        .filt_o     (dig_filt)
    );

    supmon_filter u_ana_filter (
        .CORE_CLK_I (CORE_CLK_I),
        .SYS_RST_I  (SYS_RST_I),
        .cmp_i      (ANA_CMP_I),
        .level_o    (),
        .filt_o     (ana_filt)
    );

    assign reg_hit_wr = SFR_WR_I && ctrl_hit(SFR_ADDR_I);
    assign reg_hit_rd = SFR_RD_I && ctrl_hit(SFR_ADDR_I);

    // A disabled monitor reports no low supply, so a stale low cannot pin the flag
    assign supply_low = enable_reg && (!dig_filt || !ana_filt);

    // Control fields
    always_comb begin
        enable_next = enable_reg;
        trip_next   = trip_reg;
        if (reg_hit_wr) begin
            enable_next = SFR_WDATA_I[supmon_pkg::BIT_ENABLE];
            trip_next   = {SFR_WDATA_I[supmon_pkg::BIT_TRIP_HI],
                           SFR_WDATA_I[supmon_pkg::BIT_TRIP_LO]};
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            enable_reg <= supmon_pkg::CTRL_RESET[supmon_pkg::BIT_ENABLE];
            trip_reg   <= {supmon_pkg::CTRL_RESET[supmon_pkg::BIT_TRIP_HI],
                           supmon_pkg::CTRL_RESET[supmon_pkg::BIT_TRIP_LO]};
        end else begin
            enable_reg <= enable_next;
            trip_reg   <= trip_next;
        end
    end

    // Low-supply flag and qualification sequencer
    always_comb begin
        state_next = state_reg;
        flag_next  = flag_reg;
        qual_next  = qual_reg;
        case (state_reg)
            supmon_pkg::SUPMON_IDLE: begin
                qual_next = '0;
                if (reg_hit_wr && SFR_WDATA_I[supmon_pkg::BIT_LOW_FLAG]) begin
                    flag_next  = 1'b1;
                    state_next = supmon_pkg::SUPMON_QUAL;
                end
            end
            supmon_pkg::SUPMON_LOW: begin
                qual_next = '0;
                if (!supply_low) begin
                    state_next = supmon_pkg::SUPMON_QUAL;
                end
            end
            supmon_pkg::SUPMON_QUAL: begin
                if (qual_reg == QUAL_LAST) begin
                    flag_next  = 1'b0;
                    qual_next  = '0;
                    state_next = supmon_pkg::SUPMON_IDLE;
                end else begin
                    qual_next = qual_reg + 1'b1;
                end
                // Software clear is allowed here since both supplies are good
                if (reg_hit_wr) begin
                    flag_next  = SFR_WDATA_I[supmon_pkg::BIT_LOW_FLAG];
                    qual_next  = '0;
                    state_next = SFR_WDATA_I[supmon_pkg::BIT_LOW_FLAG] ?
                                 supmon_pkg::SUPMON_QUAL : supmon_pkg::SUPMON_IDLE;
                end
            end
            default: begin
                flag_next  = 1'b1;
                qual_next  = '0;
                state_next = supmon_pkg::SUPMON_LOW;
            end
        endcase
        // A low supply overrides any write and restarts qualification from zero
        if (supply_low) begin
            flag_next  = 1'b1;
            qual_next  = '0;
            state_next = supmon_pkg::SUPMON_LOW;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            state_reg <= supmon_pkg::SUPMON_IDLE;
            flag_reg  <= supmon_pkg::CTRL_RESET[supmon_pkg::BIT_LOW_FLAG];
            qual_reg  <= '0;
        end else begin
            state_reg <= state_next;
            flag_reg  <= flag_next;
            qual_reg  <= qual_next;
        end
    end

    // Read path and interrupt request
    always_comb begin
        rdata_next = 8'h00;
        if (reg_hit_rd) begin
            rdata_next = supmon_pkg::CTRL_RESET & supmon_pkg::CTRL_FIXED_MASK;
            rdata_next[supmon_pkg::BIT_DIG_CMP]  = dig_level;
            rdata_next[supmon_pkg::BIT_LOW_FLAG] = flag_reg;
            rdata_next[supmon_pkg::BIT_TRIP_HI]  = trip_reg[1];
            rdata_next[supmon_pkg::BIT_TRIP_LO]  = trip_reg[0];
            rdata_next[supmon_pkg::BIT_ENABLE]   = enable_reg;
        end
        irq_next = flag_reg && IRQ_ENABLE_I;
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            rdata_reg <= 8'h00;
            irq_reg   <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            irq_reg   <= irq_next;
        end
    end

    assign SFR_RDATA_O      = rdata_reg;
    assign MONITOR_ENABLE_O = enable_reg;
    assign TRIP_SELECT_O    = trip_reg;
    assign LOW_SUPPLY_IRQ_O = irq_reg;

endmodule : supmon_top

// ---- supmon_chk.sv ----
// Checker for supmon_top: bus answers, control outputs, flag and irq timing.
// Assumes it is bound to supmon_top and sees only its ports.
`timescale 1ns/1ns
module supmon_chk #(
    parameter logic [supmon_pkg::QUAL_CNT_W-1:0] QUAL_CYCLES = 23'h64
) (
    input wire logic       CORE_CLK_I,       // Clock
    input wire logic       SYS_RST_I,        // Reset
    input wire logic [7:0] SFR_ADDR_I,       // Address
    input wire logic [7:0] SFR_WDATA_I,      // Write data
    input wire logic       SFR_WR_I,         // Write
    input wire logic       SFR_RD_I,         // Read
    input wire logic       IRQ_ENABLE_I,     // Irq enable
    input wire logic       DIG_CMP_I,        // Digital good
    input wire logic       ANA_CMP_I,        // Analog good
    input wire logic [7:0] SFR_RDATA_O,      // Read data
    input wire logic       MONITOR_ENABLE_O, // Monitor on
    input wire logic [1:0] TRIP_SELECT_O,    // Trip code
    input wire logic       LOW_SUPPLY_IRQ_O  // Irq
);
    logic [15:0] good_reg, good_next; // Good cycles without a write
    logic [7:0]  low_reg, low_next;   // Low cycles while armed
    wire         wr_ctrl = SFR_WR_I && SFR_ADDR_I == 8'hDF;
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    always_comb begin
        good_next = (DIG_CMP_I && ANA_CMP_I && !SFR_WR_I) ? good_reg + {15'h0, ~&good_reg} : 16'h0;
        low_next = ((!DIG_CMP_I || !ANA_CMP_I) && MONITOR_ENABLE_O && IRQ_ENABLE_I) ? low_reg + {7'h0, ~&low_reg} : 8'h0;
    end
    always_ff @(posedge CORE_CLK_I) begin
        good_reg <= SYS_RST_I ? 16'h0 : good_next;
        low_reg  <= SYS_RST_I ? 8'h0 : low_next;
    end
    property p_rd_idle; !$past(SFR_RD_I) |-> SFR_RDATA_O == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_en_wr; wr_ctrl |=> {7'h0, MONITOR_ENABLE_O} == ($past(SFR_WDATA_I) & 8'h01); endproperty
    a_en_wr: assert property (p_en_wr) else $error("enable not written");
    property p_trip_wr; wr_ctrl |=> {3'h0, TRIP_SELECT_O, 3'h0} == ($past(SFR_WDATA_I) & 8'h18); endproperty
    a_trip_wr: assert property (p_trip_wr) else $error("trip not written");
    property p_hold; !wr_ctrl |=> $stable(TRIP_SELECT_O) && $stable(MONITOR_ENABLE_O); endproperty
    a_hold: assert property (p_hold) else $error("control changed without write");
    property p_irq_gate; !$past(IRQ_ENABLE_I) |-> !LOW_SUPPLY_IRQ_O; endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");
    property p_low_sets; low_reg == 8'd64 |-> LOW_SUPPLY_IRQ_O; endproperty
    a_low_sets: assert property (p_low_sets) else $error("low supply not flagged");
    property p_quiet; good_reg >= 16'd60 && $past(IRQ_ENABLE_I) && !LOW_SUPPLY_IRQ_O |=> !LOW_SUPPLY_IRQ_O; endproperty
    a_quiet: assert property (p_quiet) else $error("flag set with good supplies");
    property p_qual_hold;
        IRQ_ENABLE_I && LOW_SUPPLY_IRQ_O && !$past(SFR_WR_I) && good_reg + 16'd4 < QUAL_CYCLES |=> LOW_SUPPLY_IRQ_O;
    endproperty
    a_qual_hold: assert property (p_qual_hold) else $error("flag cleared early");
    property p_qual_clr; good_reg == QUAL_CYCLES + 16'd70 |-> !LOW_SUPPLY_IRQ_O; endproperty
    a_qual_clr: assert property (p_qual_clr) else $error("flag not cleared");
endmodule : supmon_chk
bind supmon_top supmon_chk #(.QUAL_CYCLES(QUAL_CYCLES)) u_chk (.CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I),
    .SFR_ADDR_I(SFR_ADDR_I), .SFR_WDATA_I(SFR_WDATA_I), .SFR_WR_I(SFR_WR_I), .SFR_RD_I(SFR_RD_I),
    .IRQ_ENABLE_I(IRQ_ENABLE_I), .DIG_CMP_I(DIG_CMP_I), .ANA_CMP_I(ANA_CMP_I), .SFR_RDATA_O(SFR_RDATA_O),
    .MONITOR_ENABLE_O(MONITOR_ENABLE_O), .TRIP_SELECT_O(TRIP_SELECT_O), .LOW_SUPPLY_IRQ_O(LOW_SUPPLY_IRQ_O));

// ---- supmon_core_model.sv ----
// Processor core model: register bus master and irq enable bit.
// Assumes the bench calls its tasks; signals change on the falling edge.
`timescale 1ns/1ns
module supmon_core_model (
    input  wire logic clk_i,          // Core clock
    output logic [7:0] addr_o = 8'h00, // Address
    output logic [7:0] wdata_o = 8'h00,// Write data
    output logic      wr_o = 1'b0,    // Write strobe
    output logic      rd_o = 1'b0,    // Read strobe
    output logic      irq_en_o = 1'b0 // Irq enable
);
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = wr;
        rd_o = !wr;
        @(negedge clk_i);
        // Released bus shows no stale value
        addr_o = ~a;
        wdata_o = ~d;
        wr_o = 1'b0;
        rd_o = 1'b0;
    endtask : access
    task automatic set_irq(input logic v);
        @(negedge clk_i);
        irq_en_o = v;
    endtask : set_irq
endmodule : supmon_core_model

// ---- supply_monitor_interrupt_tb.sv ----
// Self-checking bench for supmon_top: registers, flag, qualification, irq.
// Assumes a short qualification count and the core model as bus master.
`timescale 1ns/1ns
module supply_monitor_interrupt_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic dig = 1'b1;
    logic ana = 1'b1;
    logic rd_d = 1'b0;
    logic [7:0] addr, wdata, rdata, r;
    logic wr, rd, irq_en, mon_en, irq;
    logic [1:0] trip;
    logic [31:0] lfsr = 32'd90392;
    logic [7:0] exp_q[$];
    int bad_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    wire [7:0] outs = {2'h0, irq, trip, 2'h0, mon_en};
    always #20 clk = ~clk;
    supmon_core_model core (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .irq_en_o(irq_en));
    supmon_top #(.QUAL_CYCLES(23'h64)) uut (.CORE_CLK_I(clk), .SYS_RST_I(rst), .SFR_ADDR_I(addr),
        .SFR_WDATA_I(wdata), .SFR_WR_I(wr), .SFR_RD_I(rd), .IRQ_ENABLE_I(irq_en), .DIG_CMP_I(dig),
        .ANA_CMP_I(ana), .SFR_RDATA_O(rdata), .MONITOR_ENABLE_O(mon_en), .TRIP_SELECT_O(trip),
        .LOW_SUPPLY_IRQ_O(irq));
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction : rnd
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        core.access(1'b0, a, 8'h00);
    endtask : rd_exp
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    // Read data stands one cycle after the strobe edge
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk) begin
        if (rd_d) chk("read data", exp_q.pop_front(), rdata);
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        idle(5);
        rst = 1'b0;
        chk("reset outputs", 8'h18, outs);
        rd_exp(8'hDF, 8'hDE);
        r = rnd();
        rd_exp({r[7:1], 1'b0}, 8'h00);
        for (int c = 0; c < 4; c++) begin
            r = rnd();
            core.access(1'b1, 8'hDF, {r[7:6], 1'b0, c[1:0], r[2:1], 1'b1});
            chk("control outputs", {3'h0, c[1:0], 3'h1}, outs);
            rd_exp(8'hDF, {3'b110, c[1:0], 3'b111});
        end
        $display("done register");
        core.access(1'b1, 8'hDF, 8'h00);
        chk("disabled outputs", 8'h00, outs);
        core.set_irq(1'b1);
        dig = 1'b0;
        idle(100);
        rd_exp(8'hDF, 8'h86);
        dig = 1'b1;
        // Let the filtered level recover before enabling, or the stale low would set the flag
        idle(60);
        core.access(1'b1, 8'hDF, 8'h01);
        idle(80);
        dig = 1'b0;
        idle(20);
        rd_exp(8'hDF, 8'h87);
        dig = 1'b1;
        idle(80);
        rd_exp(8'hDF, 8'hC7);
        $display("done glitch");
        ana = 1'b0;
        idle(100);
        chk("irq on low", 8'h21, outs);
        core.access(1'b1, 8'hDF, 8'h01);
        rd_exp(8'hDF, 8'hE7);
        core.set_irq(1'b0);
        idle(2);
        chk("irq masked", 8'h01, outs);
        core.set_irq(1'b1);
        ana = 1'b1;
        // New low must be filtered in before the interval would have expired
        idle(70);
        rd_exp(8'hDF, 8'hE7);
        dig = 1'b0;
        idle(80);
        dig = 1'b1;
        idle(100);
        rd_exp(8'hDF, 8'hE7);
        idle(180);
        rd_exp(8'hDF, 8'hC7);
        chk("irq cleared", 8'h01, outs);
        core.access(1'b1, 8'hDF, 8'h21);
        rd_exp(8'hDF, 8'hE7);
        core.access(1'b1, 8'hDF, 8'h01);
        rd_exp(8'hDF, 8'hC7);
        $display("done flag");
        idle(3);
        conclude();
    end
endmodule : supply_monitor_interrupt_tb
